// ==== hw/i2sw_cfg.svh ====
// Constants of the two-channel I2C switch controller.
// Assumes inclusion by the package and by every design file needing them.
// Notes on behaviour
// - Last address bit 1 reads the control register, 0 writes it.
// - After write address ack, the low two bits of the data byte go to the register.
// - Several bytes in one write: only the last byte is kept.
// - Register is written by I2C writes and read by I2C reads.
// - Bit 0 enables channel 0, bit 1 enables channel 1.
// - New channel selection becomes active only at a stop condition.
// - Both channels may be connected at the same time.
// - Reset and power-up clear all bits, no channel selected.
// - Interrupt output pulled low while either interrupt input is low.
// - Interrupts are reported whether or not the channel is selected.
// - Bit 4 shows channel 0 interrupt, bit 5 channel 1; 1 pending.
// - Interrupt inputs are sampled into bits 4 and 5 on a read.
// - Both interrupt bits may read as set together.
// - Interrupt inputs may serve as general inputs via status bits.
// - Reset pin low returns register and state machine to defaults.
// - Slave address is fixed upper bits plus two address pins.
`ifndef I2SW_CFG_SVH
`define I2SW_CFG_SVH
`define I2SW_ADDR_HI      5'h1c
`define I2SW_CTRL_RESET   8'h00
`define I2SW_EN_MASK      8'h03
`define I2SW_IRQ0_BIT     4
`define I2SW_IRQ1_BIT     5
`endif

// ==== hw/i2sw_pkg.sv ====
// Types of the two-channel I2C switch controller.
// Assumes the constants header is available on the include path.
package i2sw_pkg;
`include "i2sw_cfg.svh"
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b010,
        ST_WDAT = 3'b011,
        ST_WACK = 3'b100,
        ST_RDAT = 3'b101,
        ST_RACK = 3'b110
    } i2sw_state_t;
endpackage

// ==== hw/i2sw_sync.sv ====
// Two-flop synchroniser for a bundle of levels.
// Assumes the inputs are asynchronous to clk_in.
`timescale 1ns/1ps
module i2sw_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    input  wire logic [WIDTH-1:0] d_in,
    input  wire logic [WIDTH-1:0] rst_val_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_q;
    initial
    begin
        if (WIDTH < 1) $error("WIDTH must be at least 1");
    end
    // Reset to all ones: idle level of every bus and interrupt line
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            meta_q <= '1;
            q_out  <= '1;
        end
        else
        begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule // i2sw_sync

// ==== hw/i2sw_ctrl.sv ====
// Control logic of a two-channel I2C bus switch: slave engine, control
// register, delayed channel enable and interrupt combining.
// Assumes SCL/SDA and interrupt pins are asynchronous; oversampled on clk.
`timescale 1ns/1ps
`include "i2sw_cfg.svh"
module i2sw_ctrl (
    input  wire logic clk_sys_in,
    input  wire logic nrst_in,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_n_out,
    input  wire logic addr_pin_low,
    input  wire logic addr_pin_high,
    input  wire logic chan0_irq_in_n,
    input  wire logic chan1_irq_in_n,
    output logic      irq_out,
    output logic      irq_oe_n_out,
    output logic      chan0_enable_bit,
    output logic      chan1_enable_bit,
    output logic      busy_out
);
    import i2sw_pkg::*;

    // ****************************************************
    // Input synchronisers
    // ****************************************************
    logic [3:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       irq0_n_s;
    logic       irq1_n_s;
    i2sw_sync #(.WIDTH(4)) u_sync (
        .clk_in     (clk_sys_in),
        .nrst_in    (nrst_in),
        .d_in       ({chan1_irq_in_n, chan0_irq_in_n, sda_in, scl_in}),
        .rst_val_in (4'hf),
        .q_out      (pins_s)
    );
    assign scl_s    = pins_s[0];
    assign sda_s    = pins_s[1];
    assign irq0_n_s = pins_s[2];
    assign irq1_n_s = pins_s[3];

    logic scl_q;
    logic sda_q;
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl_rise  = scl_s & ~scl_q;
    assign scl_fall  = ~scl_s & scl_q;
    assign start_det = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

    // ****************************************************
    // Serial engine
    // ****************************************************
    i2sw_state_t state_q;
    logic [7:0]  shift_q;
    logic [2:0]  bit_q;
    logic [7:0]  ctrl_q;
    logic        pend_q;
    logic [6:0]  own_addr;
    logic        addr_match;
    logic        wr_done;
    logic        rd_load;
    logic        rx_full_q;
    logic [7:0]  rd_byte;

    // Status byte: bit 4 channel 0, bit 5 channel 1
    assign rd_byte = {2'b00, ~irq1_n_s, ~irq0_n_s, 2'b00, ctrl_q[1:0]};

    // Eight bits seen; the fall inside a start must not look like a byte end
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            rx_full_q <= 1'b0;
        else if (start_det || stop_det || scl_fall)
            rx_full_q <= 1'b0;
        else if (scl_rise && bit_q == 3'h7 &&
                 (state_q == ST_ADDR || state_q == ST_WDAT))
            rx_full_q <= 1'b1;
    end

    // Address from fixed bits and pins
    assign own_addr   = {`I2SW_ADDR_HI, addr_pin_high, addr_pin_low};
    assign addr_match = (shift_q[7:1] == own_addr);
    assign wr_done    = (state_q == ST_WDAT) && scl_rise && (bit_q == 3'h7);
    assign rd_load    = (state_q == ST_AACK) && scl_fall && shift_q[0];

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            bit_q   <= 3'h0;
        end
        else if (start_det)
        begin
            state_q <= ST_ADDR;
            bit_q   <= 3'h0;
        end
        else if (stop_det)
            state_q <= ST_IDLE;
        else
        begin
            case (state_q)
                ST_IDLE: ;
                ST_ADDR, ST_WDAT:
                    if (scl_rise)
                    begin
                        shift_q <= {shift_q[6:0], sda_s};
                        bit_q   <= bit_q + 3'h1;
                    end
                    else if (scl_fall && rx_full_q)
                    begin
                        if (state_q == ST_ADDR && !addr_match)
                            state_q <= ST_IDLE;
                        else
                            state_q <= (state_q == ST_ADDR) ? ST_AACK
                                                            : ST_WACK;
                    end
                ST_AACK:
                    if (scl_fall)
                    begin
                        if (shift_q[0])
                        begin
                            state_q <= ST_RDAT;
                            shift_q <= rd_byte;
                        end
                        else
                            state_q <= ST_WDAT;
                    end
                ST_WACK:
                    if (scl_fall)
                        state_q <= ST_WDAT;
                ST_RDAT:
                    if (scl_fall)
                    begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        bit_q   <= bit_q + 3'h1;
                        if (bit_q == 3'h7)
                            state_q <= ST_RACK;
                    end
                ST_RACK:
                    if (scl_rise)
                        state_q <= sda_s ? ST_IDLE : ST_RACK;
                    else if (scl_fall)
                        state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************
    // Control register
    // ****************************************************
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            ctrl_q <= `I2SW_CTRL_RESET;
        // Each byte overwrites; last one stays
        else if (wr_done)
            ctrl_q[1:0] <= {shift_q[0], sda_s};
        else if (rd_load)
        begin
            ctrl_q[`I2SW_IRQ0_BIT] <= ~irq0_n_s;
            ctrl_q[`I2SW_IRQ1_BIT] <= ~irq1_n_s;
        end
    end

    // Write pending until stop, so the switch closes on idle lines
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            pend_q <= 1'b0;
        else if (wr_done)
            pend_q <= 1'b1;
        else if (stop_det)
            pend_q <= 1'b0;
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            chan0_enable_bit <= 1'b0;
            chan1_enable_bit <= 1'b0;
        end
        else if (stop_det && pend_q)
        begin
            chan0_enable_bit <= ctrl_q[0];
            chan1_enable_bit <= ctrl_q[1];
        end
    end

    // ****************************************************
    // Pin drive
    // ****************************************************
    logic sda_low_q;
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            sda_low_q <= 1'b0;
        else if (start_det || stop_det)
            sda_low_q <= 1'b0;
        else if (scl_fall)
        begin
            // Ack matched address and written bytes
            if (state_q == ST_ADDR && rx_full_q && addr_match)
                sda_low_q <= 1'b1;
            else if (state_q == ST_WDAT && rx_full_q)
                sda_low_q <= 1'b1;
            else if (state_q == ST_AACK && shift_q[0])
                sda_low_q <= ~rd_byte[7];
            else if (state_q == ST_RDAT && bit_q != 3'h7)
                sda_low_q <= ~shift_q[6];
            else
                sda_low_q <= 1'b0;
        end
    end
    assign sda_out      = 1'b0;
    assign sda_oe_n_out = ~sda_low_q;

    logic irq_low_q;
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            irq_low_q <= 1'b0;
        else
            irq_low_q <= ~irq0_n_s | ~irq1_n_s;
    end
    assign irq_out      = 1'b0;
    assign irq_oe_n_out = ~irq_low_q;
    assign busy_out     = (state_q != ST_IDLE);

    // ****************************************************
    // Checks
    // ****************************************************
    a_irq_combine: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (!irq0_n_s || !irq1_n_s) |=> !irq_oe_n_out)
        else $error("interrupt output not driven");
    a_en_on_stop: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        $changed(chan0_enable_bit) |-> $past(stop_det))
        else $error("channel changed outside stop");
    a_unused_zero: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        ctrl_q[7:6] == 2'b00 && ctrl_q[3:2] == 2'b00)
        else $error("unused bits set");
    a_irq_release: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (irq0_n_s && irq1_n_s) |=> irq_oe_n_out)
        else $error("interrupt stuck");
    a_idle_nodrive: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        stop_det |=> sda_oe_n_out)
        else $error("sda driven after stop");
    a_wr_pend: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        wr_done |=> pend_q)
        else $error("write not pending");
    a_rd_dir: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        rd_load |=> state_q == ST_RDAT)
        else $error("read direction wrong");
    a_rst_clear: assert property (@(posedge clk_sys_in)
        $rose(nrst_in) |-> ctrl_q == 8'h00 && !chan0_enable_bit)
        else $error("reset value wrong");
    c_write: cover property (@(posedge clk_sys_in) wr_done);
    c_read: cover property (@(posedge clk_sys_in) rd_load);
    c_both: cover property (@(posedge clk_sys_in)
        chan0_enable_bit && chan1_enable_bit);
endmodule // i2sw_ctrl

// ==== verification/i2sw_master_model.sv ====
// Behavioural upstream bus master that drives SCL and releases SDA.
// Assumes SDA is a wired-AND line with a pull-up outside this model.
`timescale 1ns/1ps
module i2sw_master_model (
    input  wire logic clk_link_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_rel_out
);
    // ************************************************************
    // Bus phases
    // ************************************************************
    initial
    begin
        scl_out = 1'b1;
        sda_rel_out = 1'b1;
    end
    // Tick of 4 link clocks, a third of a bit, keeps SCL slow enough
    task automatic tick();
        repeat (4) @(posedge clk_link_in);
        #1;
    endtask
    task automatic bit_out(input logic b);
        sda_rel_out = b;
        tick();
        scl_out = 1'b1;
        tick();
        scl_out = 1'b0;
        tick();
    endtask
    task automatic bit_in(output logic b);
        sda_rel_out = 1'b1;
        tick();
        scl_out = 1'b1;
        tick();
        b = sda_in;
        scl_out = 1'b0;
        tick();
    endtask
    task automatic start_cond();
        sda_rel_out = 1'b1;
        tick();
        scl_out = 1'b1;
        tick();
        sda_rel_out = 1'b0;
        tick();
        scl_out = 1'b0;
        tick();
    endtask
    task automatic stop_cond();
        sda_rel_out = 1'b0;
        tick();
        scl_out = 1'b1;
        tick();
        sda_rel_out = 1'b1;
        tick();
    endtask
    task automatic byte_out(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_out(d[i]);
        bit_in(a);
        ack = ~a;
    endtask
    task automatic byte_in(output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            bit_in(d[i]);
        // No ack ends the read
        bit_out(1'b1);
    endtask
endmodule // i2sw_master_model

// ==== verification/test_i2c_two_channel_switch_ctrl.sv ====
// Self-checking bench for the two-channel switch control logic.
// Assumes the design sources and the master model are compiled first.
`timescale 1ns/1ps
`include "i2sw_cfg.svh"
module test_i2c_two_channel_switch_ctrl;
    import i2sw_pkg::*;
    logic       clk_sys_in = 1'b0;
    logic       clk_link   = 1'b0;
    logic       nrst_in    = 1'b0;
    logic       a_lo       = 1'b0;
    logic       a_hi       = 1'b0;
    logic       irq0_n     = 1'b1;
    logic       irq1_n     = 1'b1;
    logic       scl;
    logic       m_rel;
    logic       sda_oe_n;
    logic       irq_oe_n;
    logic       en0;
    logic       en1;
    logic       ack;
    logic [1:0] en_exp = 2'b00;
    logic [7:0] rd;
    logic [7:0] b0;
    logic [7:0] b1;
    int         errors = 0;
    int         cmp_count = 0;
    wire        sda_line = m_rel & sda_oe_n;
    always #2.5 clk_sys_in = ~clk_sys_in;
    always #6 clk_link = ~clk_link;
    i2sw_ctrl dut (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .scl_in(scl),
        .sda_in(sda_line), .sda_out(), .sda_oe_n_out(sda_oe_n),
        .addr_pin_low(a_lo), .addr_pin_high(a_hi),
        .chan0_irq_in_n(irq0_n), .chan1_irq_in_n(irq1_n), .irq_out(),
        .irq_oe_n_out(irq_oe_n), .chan0_enable_bit(en0),
        .chan1_enable_bit(en1), .busy_out()
    );
    i2sw_master_model mst (
        .clk_link_in(clk_link), .sda_in(sda_line),
        .scl_out(scl), .sda_rel_out(m_rel)
    );
    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            errors++;
        end
    endtask
    task automatic sys_wait(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    function automatic logic [7:0] addr(input logic rd_b);
        return {`I2SW_ADDR_HI, a_hi, a_lo, rd_b};
    endfunction
    task automatic wr(input logic [7:0] d0, input logic [7:0] d1,
                      input logic two);
        mst.start_cond();
        mst.byte_out(addr(1'b0), ack);
        chk("addr ack", 8'h01, {7'h00, ack});
        mst.byte_out(d0, ack);
        if (two)
            mst.byte_out(d1, ack);
        chk("data ack", 8'h01, {7'h00, ack});
        chk("en pre stop", {6'h00, en_exp}, {6'h00, en1, en0});
        mst.stop_cond();
        sys_wait(10);
        en_exp = two ? d1[1:0] : d0[1:0];
        chk("en", {6'h00, en_exp}, {6'h00, en1, en0});
    endtask
    task automatic rd_chk();
        mst.start_cond();
        mst.byte_out(addr(1'b1), ack);
        mst.byte_in(rd);
        mst.stop_cond();
        chk("read", {2'b00, ~irq1_n, ~irq0_n, 2'b00, en_exp}, rd);
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ************************************************************
    // Sequence
    // ************************************************************
    initial
    begin
        b0 = 8'($urandom(32'hcfbb));
        {a_hi, a_lo} = 2'($urandom);
        sys_wait(10);
        nrst_in = 1'b1;
        sys_wait(5);
        chk("en reset", 8'h00, {6'h00, en1, en0});
        rd_chk();
        // Upper bits all set: they must not stick
        for (int i = 0; i < 4; i++)
            wr(8'hfc | 8'(i), 8'h00, 1'b0);
        rd_chk();
        for (int i = 0; i < 6; i++)
        begin
            b0 = 8'($urandom);
            b1 = 8'($urandom);
            wr(b0, b1, 1'($urandom));
            {irq1_n, irq0_n} = 2'($urandom);
            sys_wait(5);
            chk("irq", {7'h00, irq0_n & irq1_n}, {7'h00, irq_oe_n});
            rd_chk();
        end
        wr(8'h00, 8'h00, 1'b0);
        irq0_n = 1'b0;
        irq1_n = 1'b0;
        sys_wait(5);
        chk("irq both", 8'h00, {7'h00, irq_oe_n});
        rd_chk();
        // Status read above, then both flagged channels are selected
        wr(8'h55, 8'hab, 1'b1);
        mst.start_cond();
        mst.byte_out(addr(1'b0) ^ 8'h02, ack);
        chk("foreign nack", 8'h00, {7'h00, ack});
        mst.byte_out(8'h00, ack);
        mst.stop_cond();
        sys_wait(10);
        chk("foreign en", {6'h00, en_exp}, {6'h00, en1, en0});
        nrst_in = 1'b0;
        sys_wait(2);
        en_exp = 2'b00;
        chk("en in reset", 8'h00, {6'h00, en1, en0});
        nrst_in = 1'b1;
        sys_wait(5);
        rd_chk();
        report_and_stop();
    end
    // Whole run is near 75 us; a hang ends at the 400 us watchdog
    initial
    begin
        #400000;
        errors++;
        $display("[FAIL] watchdog expected done seen hang");
        report_and_stop();
    end
endmodule // test_i2c_two_channel_switch_ctrl
